// *** rtl/swq_sweep_sequencer.sv ***
// Converter sequencer with Wishbone register file and trigger input.
// Assumes the analog core delivers a right-justified result on convData
// in the cycle that the timer reports done.
// Operation
// - Sweep mode 0 cycles selected pins forever
// - Sweep count picks lowest 2,4,6,8 inputs
// - Software trigger starts on start bit
// - Pin trigger needs falling edge after start
// - Repeat sweeps run until start cleared, no interrupt
// - Sweep mode 1 converts all, priority first
// - One priority pin alternates with each other
// - Priority set is lowest 1 to 4
// - Result lands in register of converted pin
// - Group select picks one of four groups
// - Ten-bit fills bits 0-9, eight-bit 0-7
// - Sample-hold pin takes 28 or 33 cycles
// - Extended inputs only in one-shot and repeat
// - Extended a to result 0, b to 1
// - Op-amp mode routes out a, converts b
`include "swq_defs.svh"

module swq_sweep_sequencer #(
  parameter int unsigned DATA_W      = 10,
  parameter int unsigned CNT_W       = 6,
  parameter int unsigned CYC_NOSH_8  = `SWQ_CYC_NOSH_8,
  parameter int unsigned CYC_NOSH_10 = `SWQ_CYC_NOSH_10
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              wb_cyc_i,
  input  wire logic              wb_stb_i,
  input  wire logic              wb_we_i,
  input  wire logic [7:0]        wb_adr_i,
  input  wire logic [3:0]        wb_sel_i,
  input  wire logic [31:0]       wb_dat_i,
  output logic      [31:0]       wb_dat_o,
  output logic                   wb_ack_o,
  input  wire logic              external_trigger_pin,
  input  wire logic [DATA_W-1:0] convData,
  output logic      [1:0]        anaGroup,
  output logic      [2:0]        anaChan,
  output swq_pkg::swq_src_t      sampleSource,
  output logic                   opAmpRoute,
  output logic                   sampleHold,
  output logic                   tenBitMode,
  output logic                   refConnect,
  output logic                   sampleStart,
  output logic                   convBusy
);
  import swq_pkg::*;

  logic [7:0]        ctrl0_r;
  logic [7:0]        ctrl0_nxt;
  logic [7:0]        ctrl1_r;
  logic [7:0]        ctrl1_nxt;
  logic [7:0]        ctrl2_r;
  logic [7:0]        ctrl2_nxt;
  logic              ack_r;
  logic              ack_nxt;
  logic [31:0]       dat_r;
  logic [31:0]       dat_nxt;
  logic [DATA_W-1:0] result_r [0:7];
  logic [DATA_W-1:0] res_nxt  [0:7];
  swq_state_t        state_r;
  swq_state_t        state_nxt;
  logic [2:0]        chan_r;
  logic [2:0]        chan_nxt;
  logic [2:0]        other_r;
  logic [2:0]        other_nxt;
  logic              syncA_r;
  logic              syncB_r;
  logic              trigPrev_r;
  logic              trigFall;
  logic              timerStart;
  logic              timerAbort;
  logic              timerDone;
  logic              timerBusy;
  logic              resWr;
  logic              hwClearStart;
  logic [5:0]        word;
  logic              reqNew;
  logic              wrEn;
  logic [2:0]        mode;
  logic              trigSel;
  logic              startBit;
  logic [1:0]        countField;
  logic [1:0]        extSel;
  logic              extActive;
  logic [2:0]        lastChan;
  logic [2:0]        prioLast;
  logic [2:0]        firstOther;
  logic [2:0]        firstChan;
  logic [2:0]        destIdx;
  logic [DATA_W-1:0] resVal;
  logic [CNT_W-1:0]  pinCycles;

  assign word       = wb_adr_i[7:2];
  assign reqNew     = wb_cyc_i && wb_stb_i && !ack_r;
  assign wrEn       = reqNew && wb_we_i && wb_sel_i[0];
  assign mode       = ctrl0_r[`SWQ_C0_MODE_LSB +: 3];
  assign trigSel    = ctrl0_r[`SWQ_C0_TRIG_BIT];
  assign startBit   = ctrl0_r[`SWQ_C0_START_BIT];
  assign countField = ctrl1_r[`SWQ_C1_COUNT_LSB +: 2];
  assign extSel     = ctrl1_r[`SWQ_C1_EXT_LSB +: 2];
  assign tenBitMode = ctrl1_r[`SWQ_C1_TENBIT_BIT];
  assign refConnect = ctrl1_r[`SWQ_C1_REFCON_BIT];
  assign sampleHold = ctrl2_r[`SWQ_C2_SH_BIT];
  assign anaGroup   = ctrl2_r[`SWQ_C2_GROUP_LSB +: 2];
  assign anaChan    = chan_r;
  assign convBusy   = (state_r != SWQ_IDLE);
  assign sampleStart = timerStart;
  assign wb_ack_o   = ack_r;
  assign wb_dat_o   = dat_r;

  // Extended pins are honoured only in one-shot and repeat modes
  assign extActive  = ((mode == `SWQ_MODE_ONESHOT) ||
                       (mode == `SWQ_MODE_REPEAT)) &&
                      (extSel != `SWQ_EXT_NONE);
  assign opAmpRoute = extActive && (extSel == `SWQ_EXT_OPAMP);
  assign lastChan   = {countField, 1'b1};
  assign prioLast   = {1'b0, countField};
  assign firstOther = 3'({1'b0, countField} + 3'd1);
  assign firstChan  = ((mode == `SWQ_MODE_ONESHOT) ||
                       (mode == `SWQ_MODE_REPEAT)) ?
                      ctrl0_r[`SWQ_C0_CHAN_LSB +: 3] : 3'h0;
  assign resVal     = tenBitMode ? convData :
                      {{(DATA_W-8){1'b0}}, convData[7:0]};
  assign pinCycles  = sampleHold ?
    (tenBitMode ? CNT_W'(`SWQ_CYC_SH_10) : CNT_W'(`SWQ_CYC_SH_8)) :
    (tenBitMode ? CNT_W'(CYC_NOSH_10) : CNT_W'(CYC_NOSH_8));

  always_comb begin
    sampleSource = SWQ_SRC_GROUP;
    destIdx      = chan_r;
    if (extActive) begin
      if (extSel == `SWQ_EXT_A) begin
        sampleSource = SWQ_SRC_EXT_A;
        destIdx      = 3'h0;
      end else if (extSel == `SWQ_EXT_B) begin
        sampleSource = SWQ_SRC_EXT_B;
        destIdx      = 3'h1;
      end else begin
        sampleSource = SWQ_SRC_EXT_B;
      end
    end
  end

  // Pin is asynchronous: two flops, then a third for the edge
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_r    <= 1'b1;
      syncB_r    <= 1'b1;
      trigPrev_r <= 1'b1;
    end else begin
      syncA_r    <= external_trigger_pin;
      syncB_r    <= syncA_r;
      trigPrev_r <= syncB_r;
    end
  end
  assign trigFall = trigPrev_r && !syncB_r;

  swq_conv_timer #(
    .CNT_W (CNT_W)
  ) u_timer (
    .clk        (clk),
    .reset_n    (reset_n),
    .startPulse (timerStart),
    .abort      (timerAbort),
    .cycles     (pinCycles),
    .busy       (timerBusy),
    .done       (timerDone)
  );

  // No interrupt exists: repeating modes only stop on a cleared start bit
  always_comb begin
    state_nxt    = state_r;
    chan_nxt     = chan_r;
    other_nxt    = other_r;
    timerStart   = 1'b0;
    timerAbort   = 1'b0;
    resWr        = 1'b0;
    hwClearStart = 1'b0;
    case (state_r)
      SWQ_IDLE: begin
        if (startBit) begin
          chan_nxt  = firstChan;
          other_nxt = firstOther;
          if (trigSel) begin
            state_nxt = SWQ_ARM;
          end else begin
            state_nxt  = SWQ_CONV;
            timerStart = 1'b1;
          end
        end
      end
      SWQ_ARM: begin
        if (!startBit) begin
          state_nxt = SWQ_IDLE;
        end else if (trigFall) begin
          state_nxt  = SWQ_CONV;
          timerStart = 1'b1;
        end
      end
      SWQ_CONV: begin
        if (!startBit) begin
          state_nxt  = SWQ_IDLE;
          timerAbort = 1'b1;
        end else if (timerDone) begin
          resWr = 1'b1;
          case (mode)
            `SWQ_MODE_REPEAT: begin
              timerStart = 1'b1;
            end
            `SWQ_MODE_SINGLE: begin
              if (chan_r == lastChan) begin
                hwClearStart = 1'b1;
                state_nxt    = SWQ_IDLE;
              end else begin
                chan_nxt   = 3'(chan_r + 3'd1);
                timerStart = 1'b1;
              end
            end
            `SWQ_MODE_SWEEP0: begin
              chan_nxt   = (chan_r == lastChan) ? 3'h0 :
                           3'(chan_r + 3'd1);
              timerStart = 1'b1;
            end
            `SWQ_MODE_SWEEP1: begin
              // Whole priority set, then one other pin, then again
              if (chan_r < firstOther && chan_r != prioLast) begin
                chan_nxt = 3'(chan_r + 3'd1);
              end else if (chan_r == prioLast) begin
                chan_nxt = other_r;
              end else begin
                chan_nxt  = 3'h0;
                other_nxt = (other_r == 3'h7) ? firstOther :
                            3'(other_r + 3'd1);
              end
              timerStart = 1'b1;
            end
            default: begin
              hwClearStart = 1'b1;
              state_nxt    = SWQ_IDLE;
            end
          endcase
        end
      end
      default: begin
        state_nxt = SWQ_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= SWQ_IDLE;
      chan_r  <= 3'h0;
      other_r <= 3'h1;
    end else begin
      state_r <= state_nxt;
      chan_r  <= chan_nxt;
      other_r <= other_nxt;
    end
  end

  // A software write wins over the end-of-run clear of the start bit
  always_comb begin
    ctrl0_nxt = ctrl0_r;
    ctrl1_nxt = ctrl1_r;
    ctrl2_nxt = ctrl2_r;
    ack_nxt   = reqNew;
    dat_nxt   = dat_r;
    if (hwClearStart) begin
      ctrl0_nxt[`SWQ_C0_START_BIT] = 1'b0;
    end
    if (wrEn && word == `SWQ_WORD_CTRL0) begin
      ctrl0_nxt = wb_dat_i[7:0] & `SWQ_CTRL0_MASK;
    end else if (wrEn && word == `SWQ_WORD_CTRL1) begin
      ctrl1_nxt = wb_dat_i[7:0] & `SWQ_CTRL1_MASK;
    end else if (wrEn && word == `SWQ_WORD_CTRL2) begin
      ctrl2_nxt = wb_dat_i[7:0] & `SWQ_CTRL2_MASK;
    end
    if (reqNew) begin
      if (word == `SWQ_WORD_CTRL0) begin
        dat_nxt = {24'h00_0000, ctrl0_r};
      end else if (word == `SWQ_WORD_CTRL1) begin
        dat_nxt = {24'h00_0000, ctrl1_r};
      end else if (word == `SWQ_WORD_CTRL2) begin
        dat_nxt = {24'h00_0000, ctrl2_r};
      end else if (word == `SWQ_WORD_STATUS) begin
        dat_nxt = {26'h000_0000, chan_r, timerBusy,
                   (state_r == SWQ_ARM), convBusy};
      end else if (word[5:3] == `SWQ_WORD_RESULT_HI) begin
        dat_nxt = {{(32-DATA_W){1'b0}}, result_r[word[2:0]]};
      end else begin
        dat_nxt = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl0_r <= `SWQ_CTRL_RESET;
      ctrl1_r <= `SWQ_CTRL_RESET;
      ctrl2_r <= `SWQ_CTRL_RESET;
      ack_r   <= 1'b0;
      dat_r   <= 32'h0000_0000;
    end else begin
      ctrl0_r <= ctrl0_nxt;
      ctrl1_r <= ctrl1_nxt;
      ctrl2_r <= ctrl2_nxt;
      ack_r   <= ack_nxt;
      dat_r   <= dat_nxt;
    end
  end

  for (genvar i = 0; i < 8; i++) begin : g_res
    always_comb begin
      res_nxt[i] = result_r[i];
      if (resWr && destIdx == 3'(i)) begin
        res_nxt[i] = resVal;
      end
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        result_r[i] <= '0;
      end else begin
        result_r[i] <= res_nxt[i];
      end
    end
  end

  sw_start_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == SWQ_IDLE && startBit && !trigSel
    |=> state_r == SWQ_CONV && timerBusy)
    else $error("software start did not begin a conversion");

  trig_wait_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == SWQ_ARM && startBit && !trigFall
    |=> state_r == SWQ_ARM && !timerBusy)
    else $error("conversion began without a trigger edge");

  stop_clear_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    state_r == SWQ_CONV && !startBit |=> state_r == SWQ_IDLE ##1 !timerBusy)
    else $error("conversion kept running after start bit cleared");

  sh_length_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    timerStart && sampleHold && !tenBitMode
    |-> ##28 (timerDone || state_r != SWQ_CONV))
    else $error("eight-bit sample-hold pin not 28 cycles");

  sh_ten_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    timerStart && sampleHold && tenBitMode
    |=> !timerDone [*8] ##25 (timerDone || state_r != SWQ_CONV))
    else $error("ten-bit sample-hold pin not 33 cycles");

  result_dest_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    resWr |=> result_r[$past(destIdx)] == $past(resVal))
    else $error("result not stored for converted pin");

  res_eight_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    resWr && !tenBitMode |=> result_r[$past(destIdx)][DATA_W-1:8] == '0)
    else $error("eight-bit result spills above bit 7");

  sweep_wrap_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    mode == `SWQ_MODE_SWEEP0 && resWr && chan_r == lastChan
    |=> chan_r == 3'h0 && timerBusy && state_r == SWQ_CONV)
    else $error("sweep did not wrap to first pin");

  sweep_range_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    mode == `SWQ_MODE_SWEEP0 && state_r == SWQ_CONV |-> chan_r <= lastChan)
    else $error("sweep converts a pin outside the set");

  prio_alt_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    mode == `SWQ_MODE_SWEEP1 && countField == 2'h0 && resWr &&
    chan_r != 3'h0 |=> chan_r == 3'h0)
    else $error("priority pin not converted between others");

  ext_sweep_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    mode >= `SWQ_MODE_SINGLE |-> sampleSource == SWQ_SRC_GROUP && !opAmpRoute)
    else $error("extended input used in a sweep mode");

  opamp_src_a: assert property (
    @(posedge clk) disable iff (!reset_n)
    opAmpRoute |-> sampleSource == SWQ_SRC_EXT_B && destIdx == chan_r)
    else $error("op-amp mode converts the wrong pin");
endmodule // swq_sweep_sequencer

// *** rtl/swq_defs.svh ***
// Register offsets, field positions, codes and timing counts of the
// repeat sweep sequencer.
// Assumes a 32-bit classic Wishbone slave with word-aligned registers.
`ifndef SWQ_DEFS_SVH
`define SWQ_DEFS_SVH

// Word indices (byte address is four times the index)
`define SWQ_WORD_CTRL0      6'h00
`define SWQ_WORD_CTRL1      6'h01
`define SWQ_WORD_CTRL2      6'h02
`define SWQ_WORD_STATUS     6'h03
// Result words 0x08..0x0F: upper three index bits equal this value
`define SWQ_WORD_RESULT_HI  3'h1

`define SWQ_CTRL_RESET      8'h00
`define SWQ_CTRL0_MASK      8'hFF
`define SWQ_CTRL1_MASK      8'h3F
`define SWQ_CTRL2_MASK      8'h07

// Control zero fields
`define SWQ_C0_CHAN_LSB     0
`define SWQ_C0_MODE_LSB     3
`define SWQ_C0_TRIG_BIT     6
`define SWQ_C0_START_BIT    7
// Control one fields
`define SWQ_C1_COUNT_LSB    0
`define SWQ_C1_TENBIT_BIT   2
`define SWQ_C1_REFCON_BIT   3
`define SWQ_C1_EXT_LSB      4
// Control two fields
`define SWQ_C2_SH_BIT       0
`define SWQ_C2_GROUP_LSB    1

// Operating modes
`define SWQ_MODE_ONESHOT    3'h0
`define SWQ_MODE_REPEAT     3'h1
`define SWQ_MODE_SINGLE     3'h2
`define SWQ_MODE_SWEEP0     3'h3
`define SWQ_MODE_SWEEP1     3'h4

// Extended input select codes
`define SWQ_EXT_NONE        2'h0
`define SWQ_EXT_A           2'h1
`define SWQ_EXT_B           2'h2
`define SWQ_EXT_OPAMP       2'h3

// Converter clock cycles per pin
`define SWQ_CYC_SH_8        28
`define SWQ_CYC_SH_10       33
`define SWQ_CYC_NOSH_8      40
`define SWQ_CYC_NOSH_10     48

`endif

// *** rtl/swq_pkg.sv ***
// Types shared by the repeat sweep sequencer files.
// Assumes nothing beyond a SystemVerilog tool.
package swq_pkg;

  typedef enum logic [1:0] {
    SWQ_IDLE,
    SWQ_ARM,
    SWQ_CONV
  } swq_state_t;

  typedef enum logic [1:0] {
    SWQ_SRC_GROUP,
    SWQ_SRC_EXT_A,
    SWQ_SRC_EXT_B
  } swq_src_t;

endpackage

// *** rtl/swq_conv_timer.sv ***
// Per-pin conversion timer: counts the converter cycles of one pin.
// Assumes start and abort come from logic on the same clock.
module swq_conv_timer #(
  parameter int unsigned CNT_W = 6
) (
  input  wire logic             clk,
  input  wire logic             reset_n,
  input  wire logic             startPulse,
  input  wire logic             abort,
  input  wire logic [CNT_W-1:0] cycles,
  output logic                  busy,
  output logic                  done
);
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;

  // A start in the done cycle reloads at once, so pins follow gaplessly
  always_comb begin
    cnt_nxt = cnt_r;
    if (startPulse) begin
      cnt_nxt = cycles;
    end else if (abort) begin
      cnt_nxt = '0;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != '0);
  assign done = (cnt_r == CNT_W'(1));
endmodule // swq_conv_timer

// *** bench/swq_ana_model.sv ***
// Behavioural analog core facing the sweep sequencer.
// Assumes the sequencer samples convData in its done cycle, same clock.
module swq_ana_model (
  input  wire logic [1:0]        anaGroup,
  input  wire logic [2:0]        anaChan,
  input  wire swq_pkg::swq_src_t sampleSource,
  input  wire logic [9:0]        salt,
  output logic      [9:0]        convData
);
  timeunit 1ns;
  timeprecision 1ps;
  import swq_pkg::*;
  // Every group, pin and source gives its own code: misrouting shows
  always_comb begin
    convData = {anaGroup, anaChan, 3'(sampleSource), 2'h0} ^ salt;
  end
endmodule // swq_ana_model

// *** bench/tb_swq_sweep_sequencer.sv ***
// Self-checking bench for the repeat sweep sequencer.
// Assumes the analog model above and a 200 MHz converter clock.
`include "swq_defs.svh"
module tb_swq_sweep_sequencer;
  timeunit 1ns;
  timeprecision 1ps;
  import swq_pkg::*;
  typedef struct {
    logic [2:0] chan;
    swq_src_t   src;
    int         gap;
  } swq_exp_t;
  // mode, count, ten-bit, sample-hold, group, pin trigger, channel
  localparam logic [12:0] SCEN [11] = '{
    {3'h3, 2'd0, 1'b0, 1'b1, 2'd0, 1'b0, 3'd0},
    {3'h3, 2'd1, 1'b1, 1'b1, 2'd1, 1'b0, 3'd0},
    {3'h3, 2'd2, 1'b0, 1'b0, 2'd2, 1'b1, 3'd0},
    {3'h3, 2'd3, 1'b1, 1'b1, 2'd0, 1'b0, 3'd0},
    {3'h4, 2'd0, 1'b0, 1'b1, 2'd1, 1'b0, 3'd0},
    {3'h4, 2'd1, 1'b1, 1'b0, 2'd0, 1'b1, 3'd0},
    {3'h4, 2'd2, 1'b0, 1'b1, 2'd2, 1'b0, 3'd0},
    {3'h4, 2'd3, 1'b1, 1'b1, 2'd1, 1'b0, 3'd0},
    {3'h0, 2'd0, 1'b1, 1'b1, 2'd2, 1'b0, 3'd5},
    {3'h1, 2'd0, 1'b0, 1'b1, 2'd1, 1'b0, 3'd3},
    {3'h1, 2'd0, 1'b1, 1'b0, 2'd0, 1'b1, 3'd6}};
  logic        clk, reset_n, wbCyc, wbStb, wbWe, wbAck, trigPin;
  logic [7:0]  wbAdr;
  logic [3:0]  wbSel;
  logic [31:0] wbDatI, wbDatO, rd, rnd;
  logic [9:0]  convData, salt, ev;
  logic [1:0]  anaGroup, grp, cnt, ext;
  logic [2:0]  anaChan, mode, chan, dst;
  swq_src_t    sampleSource, src;
  logic        opAmpRoute, sampleHold, tenBitMode, refConnect;
  logic        sampleStart, convBusy, ten, sh, trigger_source_select, pend;
  int          errorCnt, checkCount, cyc, lastStart, startCnt, g, n, k;
  swq_exp_t    q[$];
  swq_exp_t    cur;

  swq_sweep_sequencer dut_u (
    .clk(clk), .reset_n(reset_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .external_trigger_pin(trigPin),
    .convData(convData), .anaGroup(anaGroup), .anaChan(anaChan),
    .sampleSource(sampleSource), .opAmpRoute(opAmpRoute),
    .sampleHold(sampleHold), .tenBitMode(tenBitMode),
    .refConnect(refConnect), .sampleStart(sampleStart), .convBusy(convBusy));
  swq_ana_model model_u (
    .anaGroup(anaGroup), .anaChan(anaChan), .sampleSource(sampleSource),
    .salt(salt), .convData(convData));

  always #2.5 clk = ~clk;

  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic finalReport;
    $display("checks %0d mismatches %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checkCount++;
    if (seen !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      errorCnt++;
    end
  endtask

  task automatic wbXfer(input logic we, input logic [5:0] word,
                        input logic [31:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    wbCyc  <= 1'b1;
    wbStb  <= 1'b1;
    wbWe   <= we;
    wbAdr  <= {word, 2'b00};
    wbDatI <= wd;
    do begin
      @(posedge clk);
      t++;
    end while (wbAck !== 1'b1 && t < 20);
    if (t >= 20) begin
      errorCnt++;
      finalReport();
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask

  task automatic push(input logic [2:0] c, input swq_src_t s);
    swq_exp_t e;
    e.chan = c;
    e.src  = s;
    e.gap  = (q.size() == 0) ? 0 : g;
    q.push_back(e);
  endtask

  // Expectation is noted once per started pin and settled a cycle later
  always @(negedge clk) begin
    if (pend) begin
      chk("channel", 32'(anaChan), 32'(cur.chan));
      chk("source", 32'(sampleSource), 32'(cur.src));
      chk("route", 32'(opAmpRoute),
          32'(mode <= `SWQ_MODE_REPEAT && ext == `SWQ_EXT_OPAMP));
      pend = 1'b0;
    end
    cyc++;
    if (sampleStart === 1'b1) begin
      startCnt++;
      if (q.size() == 0) begin
        chk("unexpected start", 32'h0000_0001, 32'h0000_0000);
      end else begin
        cur = q.pop_front();
        if (cur.gap != 0) chk("pin time", cyc - lastStart, cur.gap);
        pend = 1'b1;
      end
      lastStart = cyc;
    end
  end

  initial begin
    {clk, reset_n, wbCyc, wbStb, wbWe, pend} = '0;
    {wbAdr, wbDatI, salt} = '0;
    wbSel = 4'hF;
    trigPin = 1'b1;
    rnd = 32'h0000_1bb2;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    wbXfer(1'b0, `SWQ_WORD_CTRL0, 32'h0000_0000);
    chk("ctrl zero reset", rd, 32'h0000_0000);
    wbXfer(1'b0, 6'h3F, 32'h0000_0000);
    chk("unmapped", rd, 32'h0000_0000);
    for (int s = 0; s < 11; s++) begin
      {mode, cnt, ten, sh, grp, trigger_source_select, chan} = SCEN[s];
      ext = (mode == `SWQ_MODE_ONESHOT) ? `SWQ_EXT_OPAMP : 2'(s);
      // Extended pins only count in one-shot and repeat scenarios
      if (mode > `SWQ_MODE_REPEAT) src = SWQ_SRC_GROUP;
      else if (ext == `SWQ_EXT_A) src = SWQ_SRC_EXT_A;
      else src = SWQ_SRC_EXT_B;
      dst = (ext == `SWQ_EXT_A) ? 3'h0 : (ext == `SWQ_EXT_B) ? 3'h1 : chan;
      g = sh ? (ten ? `SWQ_CYC_SH_10 : `SWQ_CYC_SH_8)
             : (ten ? `SWQ_CYC_NOSH_10 : `SWQ_CYC_NOSH_8);
      rnd = lfsr(rnd);
      @(posedge clk);
      salt <= rnd[9:0];
      // Reference first, start in a later write
      wbXfer(1'b1, `SWQ_WORD_CTRL1, 32'({ext, 1'b1, ten, cnt}));
      wbXfer(1'b1, `SWQ_WORD_CTRL2, 32'({grp, sh}));
      chk("config", {anaGroup, tenBitMode, sampleHold, refConnect},
          {grp, ten, sh, 1'b1});
      repeat (200) @(posedge clk);
      if (mode == `SWQ_MODE_SWEEP0) begin
        for (int i = 0; i <= 2 * cnt + 1; i++) push(3'(i), SWQ_SRC_GROUP);
        push(3'd0, SWQ_SRC_GROUP);
      end else if (mode == `SWQ_MODE_SWEEP1) begin
        for (int o = cnt + 1; o < 8; o++) begin
          for (int p = 0; p <= cnt; p++) push(3'(p), SWQ_SRC_GROUP);
          push(3'(o), SWQ_SRC_GROUP);
        end
        push(3'd0, SWQ_SRC_GROUP);
      end else begin
        push(chan, src);
        if (mode == `SWQ_MODE_REPEAT) begin
          push(chan, src);
          push(chan, src);
        end
      end
      // A fall before the start bit must not count
      if (trigger_source_select) trigPin <= 1'b0;
      k = startCnt;
      wbXfer(1'b1, `SWQ_WORD_CTRL0, 32'({1'b1, trigger_source_select, mode, chan}));
      if (trigger_source_select) begin
        repeat (10) @(posedge clk);
        chk("early start", startCnt, k);
        trigPin <= 1'b1;
        repeat (4) @(posedge clk);
        trigPin <= 1'b0;
      end
      n = 0;
      while ((q.size() != 0 || pend) && n < 4000) begin
        @(posedge clk);
        n++;
      end
      if (n >= 4000) begin
        errorCnt++;
        finalReport();
      end
      if (mode != `SWQ_MODE_ONESHOT) begin
        wbXfer(1'b1, `SWQ_WORD_CTRL0, 32'({1'b0, trigger_source_select, mode, chan}));
      end
      n = 0;
      while (convBusy !== 1'b0 && n < 100) begin
        @(posedge clk);
        n++;
      end
      if (n >= 100) begin
        errorCnt++;
        finalReport();
      end
      repeat (60) @(posedge clk);
      trigPin <= 1'b1;
      wbXfer(1'b0, `SWQ_WORD_STATUS, 32'h0000_0000);
      chk("status busy", 32'(rd[0]), 32'h0000_0000);
      for (int i = 0; i < 8; i++) begin
        if ((mode == `SWQ_MODE_SWEEP0 && i <= 2 * cnt + 1) ||
            mode == `SWQ_MODE_SWEEP1 ||
            (mode <= `SWQ_MODE_REPEAT && i == dst)) begin
          ev = {grp, (mode <= `SWQ_MODE_REPEAT) ? chan : 3'(i),
                3'(src), 2'h0};
          ev = ev ^ rnd[9:0];
          if (!ten) ev[9:8] = 2'b00;
          wbXfer(1'b0, 6'h08 + 6'(i), 32'h0000_0000);
          chk("result", rd, 32'(ev));
        end
      end
    end
    finalReport();
  end
endmodule // tb_swq_sweep_sequencer
